// >>> include/tpg_pkg.sv
// Constants for the dual timer/PWM generator
//
// Operation
// - Leaving 0xFF sets overflow request flag always
// - Software counter write leaving 0xFF sets flag
// - Enable with flag set requests vector 8
// - PWM counter modulus 256, 64, 32, 16
// - Select 00 gives 256, 01 gives 64
// - Select 10 gives 32, 11 gives 16
// - Output forced high at wrap to zero
// - High while count below active reference
// - Zero reference keeps output low
// - Reference writes buffered, loaded at overflow
// - Mid-period reference write affects next period
// - Counter change alters duty in the current period
// - Flag raised once per PWM period
// - PWM enable takes pin from GPIO
// - PWM and overflow request run together
// - Two identical instances, index 0 and 1
// - PWM enable bit selects PWM output
// - Run enable zero stops counting and PWM
// - Rate code 000 divide 256, 111 divide 2
package tpg_pkg;
  localparam int TPG_NUM_CH = 2;
  localparam int TPG_DATA_W = 8;
  // Bus register byte offsets, per channel stride
  localparam logic [7:0] TPG_CH_STRIDE = 8'h10;
  localparam logic [3:0] TPG_OFS_MODE = 4'h0;
  localparam logic [3:0] TPG_OFS_COUNT = 4'h4;
  localparam logic [3:0] TPG_OFS_REF = 4'h8;
  localparam logic [3:0] TPG_OFS_STAT = 4'hc;
  localparam logic [3:0] TPG_OFS_MASK = 4'hf;
  localparam logic [7:0] TPG_ADDR_MASK = 8'h1f;
  // Mode register fields
  localparam int TPG_B_PWM_EN = 0;
  localparam int TPG_B_TOGGLE = 1;
  localparam int TPG_B_RELOAD = 2;
  localparam int TPG_B_RATE_LO = 4;
  localparam int TPG_B_RUN = 7;
  localparam int TPG_B_IRQ_EN = 8;
  localparam logic [8:0] TPG_MODE_RST = 9'h000;
  // Status register fields
  localparam int TPG_B_FLAG = 0;
  localparam int TPG_B_VEC = 1;
  // Counter constants
  localparam logic [7:0] TPG_CNT_TOP = 8'hff;
  localparam logic [7:0] TPG_CNT_RST = 8'h00;
  localparam logic [7:0] TPG_MASK_256 = 8'hff;
  localparam logic [7:0] TPG_MASK_64 = 8'h3f;
  localparam logic [7:0] TPG_MASK_32 = 8'h1f;
  localparam logic [7:0] TPG_MASK_16 = 8'h0f;
  localparam logic [7:0] TPG_IRQ_VECTOR = 8'h08;
  localparam int TPG_PRE_W = 8;
endpackage

// >>> rtl/tpg_channel.sv
// One timer/PWM channel: prescaler, counter, compare and request flag
`timescale 1ns/1ps
module tpg_channel #(
  parameter int DATA_W = tpg_pkg::TPG_DATA_W
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_run,
  input wire logic i_pwm_en,
  input wire logic i_toggle_sel,
  input wire logic i_reload_sel,
  input wire logic [2:0] i_rate,
  input wire logic i_irq_en,
  // Software writes
  input wire logic i_cnt_we,
  input wire logic i_ref_we,
  input wire logic i_flag_clr,
  input wire logic [DATA_W-1:0] i_wdata,
  // State
  output logic [DATA_W-1:0] o_count,
  output logic o_flag,
  output logic o_vec_req,
  output logic o_pwm,
  output logic o_pin_oe
);
  logic [tpg_pkg::TPG_PRE_W-1:0] pre_ff;
  logic [DATA_W-1:0] cnt_ff;
  logic [DATA_W-1:0] nxt_cnt;
  logic [DATA_W-1:0] ref_buf_ff;
  logic [DATA_W-1:0] ref_act_ff;
  logic [DATA_W-1:0] reload_mask;
  logic flag_ff;
  logic vec_ff;
  logic pwm_ff;
  logic tick;
  logic wrap;
  logic leave_top;

  // Tick when the prescaler bits below the selected divider are all ones
  always_comb begin
    logic [tpg_pkg::TPG_PRE_W-1:0] sel_mask;
    sel_mask = tpg_pkg::TPG_MASK_256 >> i_rate;
    tick = i_run && ((pre_ff & sel_mask) == sel_mask);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_ff <= '0;
    end else if (i_run) begin
      pre_ff <= pre_ff + 1'b1;
    end else begin
      pre_ff <= '0;
    end
  end

  // Modulus from reload and toggle select when PWM is enabled
  always_comb begin
    reload_mask = tpg_pkg::TPG_MASK_256;
    if (i_pwm_en) begin
      unique case ({i_reload_sel, i_toggle_sel})
        2'b00: reload_mask = tpg_pkg::TPG_MASK_256;
        2'b01: reload_mask = tpg_pkg::TPG_MASK_64;
        2'b10: reload_mask = tpg_pkg::TPG_MASK_32;
        2'b11: reload_mask = tpg_pkg::TPG_MASK_16;
      endcase
    end
  end

  assign wrap = tick && ((cnt_ff & reload_mask) == reload_mask);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (i_cnt_we) begin
      nxt_cnt = i_wdata;
    end else if (wrap) begin
      nxt_cnt = tpg_pkg::TPG_CNT_RST;
    end else if (tick) begin
      nxt_cnt = (cnt_ff + 1'b1) & reload_mask;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= tpg_pkg::TPG_CNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Leaving 0xFF by count or software write raises the flag
  assign leave_top = (cnt_ff == tpg_pkg::TPG_CNT_TOP) && (nxt_cnt != tpg_pkg::TPG_CNT_TOP);

  // Set wins over clear; in PWM mode wrap is the period overflow
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_ff <= 1'b0;
    end else if (leave_top || (i_pwm_en && wrap)) begin
      flag_ff <= 1'b1;
    end else if (i_flag_clr) begin
      flag_ff <= 1'b0;
    end
  end

  // Vector request follows enabled flag on the next cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      vec_ff <= 1'b0;
    end else begin
      vec_ff <= flag_ff && i_irq_en;
    end
  end

  // Double-buffered reference
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_buf_ff <= tpg_pkg::TPG_CNT_RST;
    end else if (i_ref_we) begin
      ref_buf_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_act_ff <= tpg_pkg::TPG_CNT_RST;
    end else if (wrap || !i_run) begin
      ref_act_ff <= ref_buf_ff;
    end
  end

  // PWM: high at wrap unless reference zero, low once count reaches reference
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pwm_ff <= 1'b0;
    end else if (!i_run || !i_pwm_en) begin
      pwm_ff <= 1'b0;
    end else if (wrap) begin
      pwm_ff <= ((ref_buf_ff & reload_mask) != tpg_pkg::TPG_CNT_RST);
    end else begin
      pwm_ff <= (nxt_cnt & reload_mask) < (ref_act_ff & reload_mask);
    end
  end

  assign o_count = cnt_ff;
  assign o_flag = flag_ff;
  assign o_vec_req = vec_ff;
  assign o_pwm = pwm_ff;
  assign o_pin_oe = i_pwm_en;
endmodule

// >>> rtl/tpg_top.sv
// AHB-Lite slave with two timer/PWM channels
`timescale 1ns/1ps
module tpg_top (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // PWM pins and GPIO takeover
  output logic [tpg_pkg::TPG_NUM_CH-1:0] o_pwm,
  output logic [tpg_pkg::TPG_NUM_CH-1:0] o_pwm_oe,
  output logic [tpg_pkg::TPG_NUM_CH-1:0] o_gpio_disable,
  // Vector request per channel
  output logic [tpg_pkg::TPG_NUM_CH-1:0] o_vec_req
);
  localparam int N = tpg_pkg::TPG_NUM_CH;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  logic [8:0] mode_ff [N];
  logic [7:0] count_w [N];
  logic [N-1:0] flag_w;
  logic [N-1:0] vec_w;
  logic [N-1:0] pwm_w;
  logic [N-1:0] oe_w;
  logic take;
  logic [7:0] rd_addr;

  function automatic logic hit(input logic [7:0] a, input int ch, input logic [3:0] ofs);
    hit = (a == (8'(ch) * tpg_pkg::TPG_CH_STRIDE + {4'h0, ofs}));
  endfunction

  assign take = i_hsel && i_hready && i_htrans[1];
  // Reads decode the same folded offset as writes
  assign rd_addr = i_haddr[7:0] & tpg_pkg::TPG_ADDR_MASK;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else if (i_hready) begin
      wr_pend_ff <= take && i_hwrite;
      wr_addr_ff <= i_haddr[7:0] & tpg_pkg::TPG_ADDR_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic cw;
      logic rw;
      logic fc;
      assign cw = wr_pend_ff && hit(wr_addr_ff, g, tpg_pkg::TPG_OFS_COUNT);
      assign rw = wr_pend_ff && hit(wr_addr_ff, g, tpg_pkg::TPG_OFS_REF);
      assign fc = wr_pend_ff && hit(wr_addr_ff, g, tpg_pkg::TPG_OFS_STAT) && i_hwdata[tpg_pkg::TPG_B_FLAG];

      always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          mode_ff[g] <= tpg_pkg::TPG_MODE_RST;
        end else if (wr_pend_ff && hit(wr_addr_ff, g, tpg_pkg::TPG_OFS_MODE)) begin
          mode_ff[g] <= i_hwdata[8:0];
        end
      end

      tpg_channel u_ch (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_run(mode_ff[g][tpg_pkg::TPG_B_RUN]),
        .i_pwm_en(mode_ff[g][tpg_pkg::TPG_B_PWM_EN]),
        .i_toggle_sel(mode_ff[g][tpg_pkg::TPG_B_TOGGLE]),
        .i_reload_sel(mode_ff[g][tpg_pkg::TPG_B_RELOAD]),
        .i_rate(mode_ff[g][tpg_pkg::TPG_B_RATE_LO +: 3]),
        .i_irq_en(mode_ff[g][tpg_pkg::TPG_B_IRQ_EN]),
        .i_cnt_we(cw),
        .i_ref_we(rw),
        .i_flag_clr(fc),
        .i_wdata(i_hwdata[7:0]),
        .o_count(count_w[g]),
        .o_flag(flag_w[g]),
        .o_vec_req(vec_w[g]),
        .o_pwm(pwm_w[g]),
        .o_pin_oe(oe_w[g])
      );
    end
  endgenerate

  // Read data registered at the address phase; reference reads as zero
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= '0;
    end else if (take && !i_hwrite) begin
      rdata_ff <= '0;
      for (int c = 0; c < N; c++) begin
        if (hit(rd_addr, c, tpg_pkg::TPG_OFS_MODE)) begin
          rdata_ff <= {23'h0, mode_ff[c]};
        end else if (hit(rd_addr, c, tpg_pkg::TPG_OFS_COUNT)) begin
          rdata_ff <= {24'h0, count_w[c]};
        end else if (hit(rd_addr, c, tpg_pkg::TPG_OFS_STAT)) begin
          rdata_ff <= {30'h0, vec_w[c], flag_w[c]};
        end
      end
    end
  end

  assign o_hrdata = rdata_ff;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_pwm = pwm_w;
  assign o_pwm_oe = oe_w;
  assign o_gpio_disable = oe_w;
  assign o_vec_req = vec_w;
endmodule

// >>> verif/tpg_top_sva.sv
// Checker for bus answers, pin takeover and vector requests of the timer/PWM block
`timescale 1ns/1ps
module tpg_top_sva (
  // Watched ports
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [1:0] o_pwm,
  input wire logic [1:0] o_pwm_oe,
  input wire logic [1:0] o_gpio_disable,
  input wire logic [1:0] o_vec_req
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic ap;
  logic wr;
  assign ap = i_hsel & i_hready & i_htrans[1];
  assign wr = ap & i_hwrite;
  AST_PIN_TAKEOVER: assert property (o_pwm_oe == o_gpio_disable)
    else $error("pin enable and gpio disable differ");
  AST_OE_BY_WRITE: assert property ($changed(o_pwm_oe) |-> $past(wr, 2))
    else $error("pin enable changed without a write");
  AST_VEC_CLEAR0: assert property ($fell(o_vec_req[0]) |-> $past(wr, 2) || $past(wr, 3))
    else $error("vector request 0 dropped without a write");
  AST_VEC_CLEAR1: assert property ($fell(o_vec_req[1]) |-> $past(wr, 2) || $past(wr, 3))
    else $error("vector request 1 dropped without a write");
  AST_REF_WRITE_ONLY: assert property (ap && !i_hwrite && i_haddr[3:0] == 4'h8 |=> o_hrdata == 32'h0)
    else $error("reference read returned data");
  AST_RDATA_HOLD: assert property ($changed(o_hrdata) |-> $past(ap && !i_hwrite))
    else $error("read data changed without a read");
  AST_BUS_OKAY: assert property (o_hreadyout && !o_hresp)
    else $error("slave stalled or answered an error");
  AST_RDATA_WIDTH: assert property (o_hrdata[31:9] == 23'h0)
    else $error("read data above bit 8 not zero");
  COV_PWM_RISE: cover property ($rose(o_pwm[0]));
  COV_VEC_RISE: cover property ($rose(o_vec_req[0]));
  COV_REF_READ: cover property (ap && !i_hwrite && i_haddr[3:0] == 4'h8);
endmodule
bind tpg_top tpg_top_sva i_tpg_top_sva (.*);

// >>> verif/test_tpg_top.sv
// Self-checking bench for the dual timer/PWM block
`timescale 1ns/1ps
module test_tpg_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hrdy;
  logic [1:0] pwm;
  logic [1:0] oe;
  logic [1:0] gd;
  logic [1:0] vec;
  logic [31:0] rd;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int per;
  int hi;
  int md[4] = '{256, 64, 32, 16};
  realtime t0;
  always #50 clk = ~clk;
  tpg_top i_tpg_top (.i_sys_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(), .o_pwm(pwm), .o_pwm_oe(oe), .o_gpio_disable(gd), .o_vec_req(vec));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // One single AHB transfer, read data left in rd
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  // Period and high time of one whole PWM period
  task meas(input int c);
    per = 0;
    hi = 0;
    // Skip a partial first period after a start or rate change
    while (pwm[c] !== 1'b1) @(posedge clk);
    while (pwm[c] !== 1'b0) @(posedge clk);
    while (pwm[c] !== 1'b1) @(posedge clk);
    do begin
      hi += (pwm[c] === 1'b1);
      per++;
      @(posedge clk);
    end while (pwm[c] !== 1'b1 || hi == per);
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      final_report;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int c = 0; c < 2; c++) begin
      for (int o = 0; o < 16; o += 4) begin
        xfer(c * 16 + o, 1'b0, 0);
        chk("reset value", 32'h0, rd);
      end
    end
    xfer(32'h2, 1'b1, 32'hff);
    xfer(32'h0, 1'b0, 0);
    chk("unmapped write", 32'h0, rd);
    xfer(32'h4, 1'b1, 32'hff);
    xfer(32'h4, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    xfer(32'hc, 1'b0, 0);
    chk("flag on leave", 32'h1, rd);
    xfer(32'h0, 1'b1, 32'h100);
    repeat (3) @(posedge clk);
    chk("vector", 32'h1, {30'h0, vec});
    xfer(32'h0, 1'b1, 32'h0);
    xfer(32'h4, 1'b1, 32'hff);
    xfer(32'h4, 1'b1, 32'h0);
    xfer(32'hc, 1'b1, 32'h1);
    xfer(32'h0, 1'b1, 32'h100);
    repeat (3) @(posedge clk);
    xfer(32'hc, 1'b0, 0);
    chk("safe rewrite", 32'h0, rd | vec[0]);
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        xfer(c * 16, 1'b1, 32'h71 | (m << 1));
        xfer(c * 16 + 8, 1'b1, md[m] / 4);
        xfer(c * 16 + 4, 1'b1, 32'h0);
        xfer(c * 16, 1'b1, 32'hf1 | (m << 1));
        meas(c);
        chk("period", 2 * md[m], per);
        chk("high", md[m] / 2, hi);
        chk("pin", 32'h3, {30'h0, gd[c], oe[c]});
      end
    end
    while (pwm[1] !== 1'b0) @(posedge clk);
    while (pwm[1] !== 1'b1) @(posedge clk);
    t0 = $realtime;
    xfer(32'h18, 1'b1, 32'hc);
    while (pwm[1] !== 1'b0) @(posedge clk);
    chk("current high", 8, int'((($realtime - t0) / 100)));
    meas(1);
    chk("next high", 24, hi);
    xfer(32'h1c, 1'b1, 32'h1);
    repeat (40) @(posedge clk);
    xfer(32'h1c, 1'b0, 0);
    chk("pwm flag", 32'h1, rd & 32'h1);
    xfer(32'h18, 1'b1, 32'h0);
    repeat (64) @(posedge clk);
    hi = 0;
    repeat (32) begin
      @(posedge clk);
      hi += (pwm[1] !== 1'b0);
    end
    chk("zero duty", 0, hi);
    xfer(32'h8, 1'b1, 32'h4);
    for (int r = 0; r < 8; r++) begin
      xfer(32'h0, 1'b1, 32'h87 | (r << 4));
      meas(0);
      chk("rate period", 32 << (7 - r), per);
      chk("rate high", 8 << (7 - r), hi);
    end
    xfer(32'h0, 1'b1, 32'h0);
    xfer(32'h4, 1'b0, 0);
    per = rd;
    repeat (20) @(posedge clk);
    xfer(32'h4, 1'b0, 0);
    chk("stopped count", per, rd);
    chk("pin released", 32'h0, {31'h0, oe[0]});
    final_report;
  end
endmodule
